// ==== rtl/halfword_mac_unit.v ====
`timescale 1ns/1ps
`include "halfword_mac_regs.vh"
// Operation
// [RQ1] cross forms multiply the first source's low-order halfword by the second source's high-order halfword.
// [RQ2] high forms multiply the high-order halfwords of both sources.
// [RQ3] low forms multiply the low-order halfwords of both sources.
// [RQ4] every selection has a signed and an unsigned variant chosen by the operation word; the code keeps negated forms signed only.
// [RQ5] wrapping accumulate adds product and target in 33 bits and keeps the low 32.
// [RQ6] signed saturation clamps to old sign then 31 inverted bits when signs agree and the sum sign flips.
// [RQ7] unsigned saturation ORs the carry across all 32 result bits.
// [RQ8] negative accumulate forms negate the signed product before adding, in all selections.
// [RQ9] negative saturation checks the sign of the negated product against the old target sign.
// [RQ10] multiply-only forms write the whole product to the target without accumulating.
// [RQ11] with the record flag set, condition field zero follows the written result; else it holds.
// [RQ12] with overflow enable set, the overflow flag and its sticky summary are updated on accumulates.
// [RQ13] bit 0 is the msb, so limits and overflow are those of 32-bit signed or unsigned values.
module halfword_mac_unit (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire [31:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
// state

reg [31:0] aw_addr_r;
reg aw_full_r;
reg [31:0] w_data_r;
reg [3:0] w_strb_r;
reg w_full_r;
reg [31:0] op_r;
reg [31:0] first_source_gpr_r;
reg [31:0] second_source_gpr_r;
reg [31:0] target_gpr_r;
reg [3:0] condition_field_zero_r;
reg arith_excess_flag_r;
reg summary_excess_flag_r;
reg [31:0] last_prod_r;
reg [31:0] exec_count_r;

////////////////////////////////////////////////////////////////////////////////
// byte-lane merge

function [31:0] merge;
	input [31:0] old;
	input [31:0] new_data;
	input [3:0] strb;
	integer i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (strb[i]) begin
				merge[i*8 +: 8] = new_data[i*8 +: 8];
			end
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// write decode

wire [7:0] w_off = {aw_addr_r[`DEC_HI:2], 2'b00};
wire w_in_window = (aw_addr_r[`ADDR_W-1:`DEC_HI+1] == 24'h000000);
wire wr_go = aw_full_r && w_full_r && !s_axi_bvalid;
wire wr_op = wr_go && w_in_window && (w_off == `OFF_OP);
wire wr_src_a = wr_go && w_in_window && (w_off == `OFF_SRC_A);
wire wr_src_b = wr_go && w_in_window && (w_off == `OFF_SRC_B);
wire wr_target = wr_go && w_in_window && (w_off == `OFF_TARGET);
wire wr_xer = wr_go && w_in_window && (w_off == `OFF_XER);
wire wr_ok = wr_op || wr_src_a || wr_src_b || wr_target || wr_xer;

////////////////////////////////////////////////////////////////////////////////
// operand selection

wire [31:0] op_now = merge(op_r, w_data_r, w_strb_r);
wire [1:0] sel = op_now[`OP_SEL_HI:`OP_SEL_LO];
wire [1:0] kind = op_now[`OP_KIND_HI:`OP_KIND_LO];
wire rec = op_now[`OP_RC];
wire oe = op_now[`OP_OE];
wire sat = op_now[`OP_SAT];
// negated forms exist only as signed
wire uns = op_now[`OP_UNS] && (kind != `KIND_NMAC);
// msb-first numbering: bits 0:15 are [31:16], bits 16:31 are [15:0]
wire [15:0] a_hi = first_source_gpr_r[31:16];
wire [15:0] a_lo = first_source_gpr_r[15:0];
wire [15:0] b_hi = second_source_gpr_r[31:16];
wire [15:0] b_lo = second_source_gpr_r[15:0];
reg [15:0] a_sel;
reg [15:0] b_sel;

always @* begin
	case (sel)
		`SEL_CROSS: begin
			a_sel = a_lo; // see [RQ1]
			b_sel = b_hi;
		end
		`SEL_HIGH: begin
			a_sel = a_hi; // see [RQ2]
			b_sel = b_hi;
		end
		default: begin
			a_sel = a_lo; // see [RQ3]
			b_sel = b_lo;
		end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// multiply, negate, accumulate

// 17-bit operands so one signed multiplier covers both variants
wire signed [16:0] a_ext = {(uns ? 1'b0 : a_sel[15]), a_sel}; // see [RQ4]
wire signed [16:0] b_ext = {(uns ? 1'b0 : b_sel[15]), b_sel}; // see [RQ4]
wire signed [33:0] prod_full = a_ext * b_ext;
wire [31:0] prod = prod_full[31:0];
wire [31:0] nprod = ~prod + 32'h00000001; // see [RQ8]
wire [31:0] addend = (kind == `KIND_NMAC) ? nprod : prod;
wire [32:0] sum = {1'b0, addend} + {1'b0, target_gpr_r}; // see [RQ5]
wire old_sign = target_gpr_r[31];
// sign of the value actually added, so negated forms compare nprod
wire sgn_ovf = (addend[31] == old_sign) && (old_sign != sum[31]); // see [RQ9]
wire uns_ovf = sum[32];
wire ovf = uns ? uns_ovf : sgn_ovf; // see [RQ13]
wire [31:0] sgn_clamp = {old_sign, {31{~old_sign}}}; // see [RQ6]
wire [31:0] uns_clamp = sum[31:0] | {32{sum[32]}}; // see [RQ7]
wire is_acc = (kind == `KIND_MAC) || (kind == `KIND_NMAC);
wire is_mul = (kind == `KIND_MUL);
wire exec_now = wr_op && (is_acc || is_mul);
reg [31:0] result;

always @* begin
	if (is_mul) begin
		result = prod; // see [RQ10]
	end else if (sat && uns) begin
		result = uns_clamp; // see [RQ7]
	end else if (sat && sgn_ovf) begin
		result = sgn_clamp; // see [RQ6]
	end else begin
		result = sum[31:0]; // see [RQ5]
	end
end

////////////////////////////////////////////////////////////////////////////////
// flag updates

wire ov_upd = exec_now && is_acc && oe;
wire ov_nxt = ov_upd ? ovf : arith_excess_flag_r; // see [RQ12]
// a software write to the exception register would win over a hardware set in the same cycle
wire so_nxt = (ov_upd && ovf) || summary_excess_flag_r; // see [RQ12]
wire [3:0] cr_nxt = {result[31], (!result[31] && (result != `ZERO32)), (result == `ZERO32), so_nxt};

////////////////////////////////////////////////////////////////////////////////
// write channels and register file

always @(posedge aclk) begin
	if (!aresetn) begin
		aw_addr_r <= `ZERO32;
		aw_full_r <= 1'b0;
		w_data_r <= `ZERO32;
		w_strb_r <= `ZERO4;
		w_full_r <= 1'b0;
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `RESP_OKAY;
		op_r <= `ZERO32;
		first_source_gpr_r <= `ZERO32;
		second_source_gpr_r <= `ZERO32;
		target_gpr_r <= `ZERO32;
		condition_field_zero_r <= `ZERO4;
		arith_excess_flag_r <= 1'b0;
		summary_excess_flag_r <= 1'b0;
		last_prod_r <= `ZERO32;
		exec_count_r <= `ZERO32;
	end else if (ce) begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_addr_r <= s_axi_awaddr;
			aw_full_r <= 1'b1;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
			w_full_r <= 1'b1;
			s_axi_wready <= 1'b0;
		end
		if (wr_go) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
		if (wr_src_a) begin
			first_source_gpr_r <= merge(first_source_gpr_r, w_data_r, w_strb_r);
		end
		if (wr_src_b) begin
			second_source_gpr_r <= merge(second_source_gpr_r, w_data_r, w_strb_r);
		end
		if (wr_target) begin
			target_gpr_r <= merge(target_gpr_r, w_data_r, w_strb_r);
		end
		if (wr_op) begin
			op_r <= op_now;
		end
		if (exec_now) begin
			target_gpr_r <= result;
			last_prod_r <= addend;
			exec_count_r <= exec_count_r + 32'h00000001;
			if (rec) begin
				condition_field_zero_r <= cr_nxt; // see [RQ11]
			end
			arith_excess_flag_r <= ov_nxt; // see [RQ12]
			summary_excess_flag_r <= so_nxt;
		end
		if (wr_xer && w_strb_r[3]) begin
			arith_excess_flag_r <= w_data_r[`XER_OV];
			summary_excess_flag_r <= w_data_r[`XER_SO];
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// read channel

wire [7:0] r_off = {s_axi_araddr[`DEC_HI:2], 2'b00};
wire r_in_window = (s_axi_araddr[`ADDR_W-1:`DEC_HI+1] == 24'h000000);
reg [31:0] rd_mux;
reg rd_hit;

always @* begin
	rd_hit = r_in_window;
	case (r_off)
		`OFF_OP: begin
			rd_mux = op_r;
		end
		`OFF_SRC_A: begin
			rd_mux = first_source_gpr_r;
		end
		`OFF_SRC_B: begin
			rd_mux = second_source_gpr_r;
		end
		`OFF_TARGET: begin
			rd_mux = target_gpr_r;
		end
		`OFF_CR0: begin
			rd_mux = {28'h0000000, condition_field_zero_r};
		end
		`OFF_XER: begin
			rd_mux = {summary_excess_flag_r, arith_excess_flag_r, 30'h00000000};
		end
		`OFF_PROD: begin
			rd_mux = last_prod_r;
		end
		`OFF_COUNT: begin
			rd_mux = exec_count_r;
		end
		default: begin
			rd_mux = `ZERO32;
			rd_hit = 1'b0;
		end
	endcase
	if (!r_in_window) begin
		rd_mux = `ZERO32;
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= `ZERO32;
		s_axi_rresp <= `RESP_OKAY;
	end else if (ce) begin
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_mux;
			s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end
		if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

endmodule

// ==== shared/halfword_mac_regs.vh ====
`ifndef HALFWORD_MAC_REGS_VH
`define HALFWORD_MAC_REGS_VH

// byte offsets on the register bus
`define ADDR_W 32
`define DEC_HI 7
`define OFF_OP 8'h00
`define OFF_SRC_A 8'h04
`define OFF_SRC_B 8'h08
`define OFF_TARGET 8'h0C
`define OFF_CR0 8'h10
`define OFF_XER 8'h14
`define OFF_PROD 8'h18
`define OFF_COUNT 8'h1C

// operation word fields
`define OP_RC 0
`define OP_SEL_LO 1
`define OP_SEL_HI 2
`define OP_KIND_LO 3
`define OP_KIND_HI 4
`define OP_UNS 5
`define OP_SAT 6
`define OP_OE 10

// operand selections
`define SEL_CROSS 2'h0
`define SEL_HIGH 2'h1
`define SEL_LOW 2'h2

// operation kinds
`define KIND_MAC 2'h0
`define KIND_NMAC 2'h1
`define KIND_MUL 2'h2

// condition field zero bits
`define CR_LT 3
`define CR_GT 2
`define CR_EQ 1
`define CR_SO 0

// exception register bits
`define XER_SO 31
`define XER_OV 30

// bus answers and reset values
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define ZERO32 32'h00000000
`define ZERO4 4'h0

`endif

// ==== verification/halfword_mac_unit_tb.sv ====
`timescale 1ns/1ps
`include "halfword_mac_regs.vh"
module halfword_mac_unit_tb;
	logic aclk, aresetn = 1'b0, ce = 1'b1;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int miscompares = 0, compares = 0, cnt = 0;
	logic [3:0] cr = 4'h0;
	halfword_mac_unit dut (.*);
	hw_mac_master m (.*);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task chk(input [31:0] g, input [31:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task end_of_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task w(input [31:0] a, input [31:0] d);
		logic [1:0] r;
		m.wr(a, d, r);
		chk(r, `RESP_OKAY);
	endtask
	function automatic [32:0] model(input [10:0] op, input [31:0] a, input [31:0] b, input [31:0] t);
		logic [15:0] x, y;
		logic [31:0] p;
		logic [32:0] s;
		logic u, ov;
		x = op[2:1] == 2'h1 ? a[31:16] : a[15:0];
		y = op[2:1] == 2'h2 ? b[15:0] : b[31:16];
		u = op[5] && op[4:3] != 2'h1;
		p = u ? {16'h0, x} * {16'h0, y} : {{16{x[15]}}, x} * {{16{y[15]}}, y};
		if (op[4:3] == 2'h1) p = -p;
		s = {1'b0, p} + {1'b0, t};
		ov = u ? s[32] : (p[31] == t[31] && s[31] != t[31]);
		if (op[4:3] == 2'h2) s = {1'b0, p};
		else if (op[6] && ov) s[31:0] = u ? 32'hFFFFFFFF : {t[31], {31{!t[31]}}};
		model = {ov && op[4:3] != 2'h2, s[31:0]};
	endfunction
	task t_reset;
		logic [31:0] d;
		logic [1:0] r;
		for (int i = 0; i < 8; i++) begin
			m.rd(i * 4, d, r);
			chk(d, 32'h0);
		end
	endtask
	task t_ops;
		logic [31:0] d, t;
		logic [1:0] r;
		logic [10:0] op;
		logic [32:0] e;
		logic so;
		w(`OFF_SRC_A, 32'h80017FFF);
		w(`OFF_SRC_B, 32'h80007FFF);
		for (int k = 0; k < 3; k++)
		for (int sel = 0; sel < 3; sel++)
		for (int kd = 0; kd < 3; kd++)
		for (int u = 0; u < 2; u++)
		for (int s = 0; s < 2; s++) begin
			t = k == 0 ? 32'h7FFFFFF0 : (k == 1 ? 32'h80000005 : 32'hFFFFFFF0);
			op = {((u ^ s) || k != 1), 3'h0, s[0], u[0], kd[1:0], sel[1:0], (s == 1 || k == 1)};
			e = model(op, 32'h80017FFF, 32'h80007FFF, t);
			so = op[10] && e[32];
			w(`OFF_TARGET, t);
			w(`OFF_XER, 32'h0);
			w(`OFF_OP, {21'h0, op});
			cnt++;
			if (op[0]) cr = {e[31], !e[31] && e[31:0] != 0, e[31:0] == 0, so};
			m.rd(`OFF_TARGET, d, r);
			chk(d, e[31:0]);
			m.rd(`OFF_XER, d, r);
			chk(d, {so, so, 30'h0});
			m.rd(`OFF_CR0, d, r);
			chk(d, {28'h0, cr});
		end
	endtask
	task t_bus;
		logic [31:0] d;
		logic [1:0] r;
		m.slow = 2;
		m.rd(32'h00000020, d, r);
		chk(d, 32'h0);
		chk(r, `RESP_SLVERR);
		m.wr(`OFF_PROD, 32'h00000001, r);
		chk(r, `RESP_SLVERR);
		m.rd(`OFF_COUNT, d, r);
		chk(d, cnt);
		m.slow = 0;
	endtask
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_ops;
		t_bus;
		end_of_test;
	end
	initial begin
		#1000000;
		miscompares++;
		end_of_test;
	end
endmodule
bind halfword_mac_unit hw_mac_props u_props (.*);

// ==== verification/hw_mac_master.sv ====
`timescale 1ns/1ps
module hw_mac_master (
	input wire aclk,
	output logic [31:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	output logic s_axi_bready,
	output logic [31:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	output logic s_axi_rready
);
	// cycles of delay before taking an answer
	int slow = 0;
	initial begin
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = 0;
		{s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
	end
	task wr(input [31:0] a, input [31:0] d, output [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= (slow == 0);
		do begin
			@(posedge aclk);
			// released lines show garbage, not the last value
			if (s_axi_awready) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (s_axi_wready) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end while (!s_axi_bvalid);
		if (slow != 0) begin
			repeat (slow) @(posedge aclk);
			s_axi_bready <= 1'b1;
			@(posedge aclk);
		end
		s_axi_bready <= 1'b0;
		r = s_axi_bresp;
	endtask
	task rd(input [31:0] a, output [31:0] d, output [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= (slow == 0);
		do begin
			@(posedge aclk);
			if (s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
		end while (!s_axi_rvalid);
		if (slow != 0) begin
			repeat (slow) @(posedge aclk);
			s_axi_rready <= 1'b1;
			@(posedge aclk);
		end
		s_axi_rready <= 1'b0;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask
endmodule

// ==== verification/hw_mac_props.sv ====
`timescale 1ns/1ps
module hw_mac_props (
	input wire aclk,
	input wire aresetn,
	input wire ce,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_wr_ans;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce |-> ##2 s_axi_bvalid;
	endproperty
	a_wr_ans: assert property (p_wr_ans) else $error("write answer not two cycles after take");
	property p_rd_ans;
		s_axi_arvalid && s_axi_arready && ce |=> s_axi_rvalid;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
	property p_b_busy;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	a_b_busy: assert property (p_b_busy) else $error("write slots open during response");
	property p_r_busy;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_r_busy: assert property (p_r_busy) else $error("read slot open during response");
	property p_b_done;
		s_axi_bvalid && s_axi_bready && ce |=> !s_axi_bvalid && s_axi_awready && s_axi_wready;
	endproperty
	a_b_done: assert property (p_b_done) else $error("write channel not reopened");
	property p_r_done;
		s_axi_rvalid && s_axi_rready && ce |=> !s_axi_rvalid && s_axi_arready;
	endproperty
	a_r_done: assert property (p_r_done) else $error("read channel not reopened");
	property p_unmap;
		s_axi_arvalid && s_axi_arready && ce && s_axi_araddr == 32'h00000020 |=>
			s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
	c_rd: cover property (s_axi_rvalid && s_axi_rready);
	c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
